/* File: core/rts_pkg.sv */
// Purpose: shared constants and carriers of the reset time-out sequencer
// Assumes: one 10 MHz reference clock
// Notes:   register indices are word indices, byte address is index * 4
package rts_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 100;
  localparam int unsigned POWER_UP_DELAY_MS  = 64;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES_DEF    =
    (POWER_UP_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned RC_DIV_DEF         = 10;
  localparam int unsigned POWER_UP_DELAY_TIMER_TICKS_DEF     = POWER_UP_DELAY_TIMER_CYCLES_DEF / RC_DIV_DEF;
  localparam int unsigned OST_PERIODS_DEF    = 1024;
  localparam int unsigned BOR_FILTER_NS      = 2000;
  localparam int unsigned BOR_FILT_CYC_DEF   =
    (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register word indices
  localparam logic [9:0]  IDX_RESET_CAUSE    = 10'h08E;
  localparam logic [9:0]  IDX_STATUS_WORD    = 10'h003;
  // Field positions
  localparam int unsigned CAUSE_BOR_BIT      = 0;
  localparam int unsigned CAUSE_POR_BIT      = 1;
  localparam int unsigned STAT_PD_BIT        = 3;
  localparam int unsigned STAT_TO_BIT        = 4;
  // Flag values after the asynchronous reset (taken as power-on)
  localparam logic        RST_POR_FLAG       = 1'b0;
  localparam logic        RST_BOR_FLAG       = 1'b0;
  localparam logic        RST_TO_FLAG        = 1'b1;
  localparam logic        RST_PD_FLAG        = 1'b1;

  localparam logic [1:0]  BOR_ALWAYS         = 2'h3;
  localparam logic [1:0]  BOR_NO_SLEEP       = 2'h2;
  localparam logic [2:0]  OSC_HS             = 3'h2;
  localparam logic [2:0]  OSC_EC             = 3'h3;

  typedef struct packed {
    logic       delay_timer_disable_fuse;
    logic [1:0] brownout_mode_fuse;
    logic [2:0] osc_mode;
  } rts_fuse_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rts_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rts_apb_rsp_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_POWER_UP_DELAY_TIMER = 4'b0010,
    ST_OST  = 4'b0100,
    ST_RUN  = 4'b1000
  } rts_state_t;

endpackage : rts_pkg

/* File: core/rts_sequencer.sv */
// Purpose: reset time-out sequencer with reset-cause flags behind APB
// Assumes: all inputs synchronous to ref_clk_i; osc_tick_i one pulse per
//          main oscillator period
// Notes:   the RC time base is a divider of the reference clock
`timescale 1ns/1ns
module rts_sequencer #(
  parameter int unsigned POWER_UP_DELAY_TIMER_TICKS   = rts_pkg::POWER_UP_DELAY_TIMER_TICKS_DEF,
  parameter int unsigned RC_DIV       = rts_pkg::RC_DIV_DEF,
  parameter int unsigned OST_PERIODS  = rts_pkg::OST_PERIODS_DEF,
  parameter int unsigned BOR_FILT_CYC = rts_pkg::BOR_FILT_CYC_DEF
) (
  input  wire logic                ref_clk_i,
  input  wire logic                resetn_i,
  input  wire rts_pkg::rts_fuse_t  fuse_i,
  input  wire logic                por_pulse_i,
  input  wire logic                vdd_low_i,
  input  wire logic                osc_tick_i,
  input  wire logic                wdt_timeout_i,
  input  wire logic                sleep_cmd_i,
  input  wire logic                irq_wake_i,
  input  wire logic                ext_reset_pin_n_i,
  input  wire rts_pkg::rts_apb_req_t apb_i,
  output logic                     apb_pready_o,
  output logic                     apb_pslverr_o,
  output logic [31:0]              apb_prdata_o,
  output logic                     core_reset_o,
  output logic                     sleeping_o
);
  import rts_pkg::*;

  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_TICKS + 1);
  localparam int OW = $clog2(OST_PERIODS + 1);
  localparam int RW = $clog2(RC_DIV + 1);
  localparam int BW = $clog2(BOR_FILT_CYC + 1);
  localparam logic [PW-1:0] POWER_UP_DELAY_TIMER_LAST = PW'(POWER_UP_DELAY_TIMER_TICKS - 1);
  localparam logic [OW-1:0] OST_LAST  = OW'(OST_PERIODS - 1);
  localparam logic [RW-1:0] RC_LAST   = RW'(RC_DIV - 1);
  localparam logic [BW-1:0] BOR_LAST  = BW'(BOR_FILT_CYC - 1);

  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode <= OSC_HS);
  endfunction : is_crystal

  function automatic logic [9:0] word_index(input logic [11:0] addr);
    word_index = addr[11:2];
  endfunction : word_index

  // ---------------- RC time base ----------------
  logic [RW-1:0] rc_cnt_q, rc_cnt_d;
  logic          rc_tick;

  always_comb begin
    rc_tick  = (rc_cnt_q == RC_LAST);
    rc_cnt_d = rc_tick ? '0 : rc_cnt_q + 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rc_cnt_q <= '0;
    end else begin
      rc_cnt_q <= rc_cnt_d;
    end
  end

  // ---------------- Brown-out filter ----------------
  logic          sleep_q, sleep_d;
  logic [BW-1:0] bor_cnt_q, bor_cnt_d;
  logic          bor_en;
  logic          bor_evt;
  logic          vdd_ok;

  always_comb begin
    bor_en = (fuse_i.brownout_mode_fuse == BOR_ALWAYS) ||
             (fuse_i.brownout_mode_fuse == BOR_NO_SLEEP && !sleep_q);
    vdd_ok = !bor_en || !vdd_low_i;
    bor_evt = 1'b0;
    bor_cnt_d = '0;
    if (bor_en && vdd_low_i) begin
      // Saturates so a long dip gives one event, not a train
      bor_cnt_d = bor_cnt_q;
      if (bor_cnt_q != BW'(BOR_FILT_CYC)) begin
        bor_cnt_d = bor_cnt_q + 1'b1;
      end
      bor_evt = (bor_cnt_q == BOR_LAST);
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bor_cnt_q <= '0;
    end else begin
      bor_cnt_q <= bor_cnt_d;
    end
  end

  // ---------------- Sequencer ----------------
  rts_state_t    state_q, state_d;
  logic          start_power_up_delay_timer_q, start_power_up_delay_timer_d;
  logic [PW-1:0] power_up_delay_timer_cnt_q, power_up_delay_timer_cnt_d;
  logic [OW-1:0] ost_cnt_q, ost_cnt_d;
  logic          pin_q;
  logic          pin_fall;
  logic          wdt_reset;
  logic          wake_evt;
  logic          core_reset_q, core_reset_d;

  always_comb begin
    pin_fall  = pin_q && !ext_reset_pin_n_i;
    wdt_reset = wdt_timeout_i && !sleep_q;
    wake_evt  = sleep_q && (irq_wake_i || wdt_timeout_i || pin_fall);
    state_d      = state_q;
    start_power_up_delay_timer_d = start_power_up_delay_timer_q;
    power_up_delay_timer_cnt_d   = power_up_delay_timer_cnt_q;
    ost_cnt_d    = ost_cnt_q;
    sleep_d      = sleep_q;
    if (por_pulse_i || bor_evt) begin
      state_d      = ST_HOLD;
      start_power_up_delay_timer_d = 1'b1;
      sleep_d      = 1'b0;
    end else if (wdt_reset) begin
      state_d = ST_HOLD;
    end else begin
      case (state_q)
        ST_HOLD: begin
          // Power-on pulse has ended here
          if (vdd_ok) begin
            start_power_up_delay_timer_d = 1'b0;
            power_up_delay_timer_cnt_d   = '0;
            ost_cnt_d    = '0;
            if (start_power_up_delay_timer_q && !fuse_i.delay_timer_disable_fuse) begin
              state_d = ST_POWER_UP_DELAY_TIMER;
            end else if (start_power_up_delay_timer_q && is_crystal(fuse_i.osc_mode)) begin
              state_d = ST_OST;
            end else begin
              state_d = ST_RUN;
            end
          end
        end
        ST_POWER_UP_DELAY_TIMER: begin
          if (rc_tick) begin
            power_up_delay_timer_cnt_d = power_up_delay_timer_cnt_q + 1'b1;
            if (power_up_delay_timer_cnt_q == POWER_UP_DELAY_TIMER_LAST) begin
              state_d = is_crystal(fuse_i.osc_mode) ? ST_OST : ST_RUN;
            end
          end
        end
        ST_OST: begin
          if (osc_tick_i) begin
            ost_cnt_d = ost_cnt_q + 1'b1;
            if (ost_cnt_q == OST_LAST) begin
              state_d = ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (sleep_cmd_i && !sleep_q) begin
            sleep_d = 1'b1;
          end else if (wake_evt) begin
            sleep_d   = 1'b0;
            ost_cnt_d = '0;
            if (is_crystal(fuse_i.osc_mode)) begin
              state_d = ST_OST;
            end
          end
        end
        default: begin
          state_d = ST_HOLD;
        end
      endcase
    end
    // Pin only gates the core; the timers carry on regardless
    core_reset_d = (state_d != ST_RUN) || !ext_reset_pin_n_i;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q      <= ST_HOLD;
      start_power_up_delay_timer_q <= 1'b1;
      power_up_delay_timer_cnt_q   <= '0;
      ost_cnt_q    <= '0;
      sleep_q      <= 1'b0;
      pin_q        <= 1'b0;
      core_reset_q <= 1'b1;
    end else begin
      state_q      <= state_d;
      start_power_up_delay_timer_q <= start_power_up_delay_timer_d;
      power_up_delay_timer_cnt_q   <= power_up_delay_timer_cnt_d;
      ost_cnt_q    <= ost_cnt_d;
      sleep_q      <= sleep_d;
      pin_q        <= ext_reset_pin_n_i;
      core_reset_q <= core_reset_d;
    end
  end

  // ---------------- Flags and APB slave ----------------
  logic         por_flag_q, por_flag_d;
  logic         bor_flag_q, bor_flag_d;
  logic         to_q, to_d;
  logic         pd_q, pd_d;
  rts_apb_rsp_t rsp_q, rsp_d;
  logic         acc;
  logic         wr_done;
  logic [9:0]   idx;

  always_comb begin
    idx     = word_index(apb_i.paddr);
    acc     = apb_i.psel && apb_i.penable;
    wr_done = acc && apb_i.pwrite && rsp_q.pready;
    rsp_d   = '0;
    if (acc && !rsp_q.pready) begin
      rsp_d.pready = 1'b1;
      case (idx)
        IDX_RESET_CAUSE: begin
          rsp_d.prdata[CAUSE_POR_BIT] = por_flag_q;
          rsp_d.prdata[CAUSE_BOR_BIT] = bor_flag_q;
        end
        IDX_STATUS_WORD: begin
          rsp_d.prdata[STAT_TO_BIT] = to_q;
          rsp_d.prdata[STAT_PD_BIT] = pd_q;
        end
        default: begin
          rsp_d.pslverr = 1'b1;
        end
      endcase
    end
    por_flag_d = por_flag_q;
    bor_flag_d = bor_flag_q;
    to_d       = to_q;
    pd_d       = pd_q;
    // Software first, hardware events after so they win on a collision
    if (wr_done && idx == IDX_RESET_CAUSE) begin
      por_flag_d = apb_i.pwdata[CAUSE_POR_BIT];
      bor_flag_d = apb_i.pwdata[CAUSE_BOR_BIT];
    end
    if (sleep_cmd_i && state_q == ST_RUN && !sleep_q) begin
      to_d = 1'b1;
      pd_d = 1'b0;
    end
    if (por_pulse_i) begin
      por_flag_d = 1'b0;
      to_d       = 1'b1;
      pd_d       = 1'b1;
    end else if (bor_evt) begin
      // Flag is meaningless with mode 00, no event can occur then
      bor_flag_d = 1'b0;
      to_d       = 1'b1;
      pd_d       = 1'b1;
    end else if (wdt_timeout_i) begin
      to_d = 1'b0;
      if (sleep_q) begin
        pd_d = 1'b0;
      end
    end else if (pin_fall && sleep_q) begin
      to_d = 1'b1;
      pd_d = 1'b0;
    end
    // Pin reset in run touches no flag at all
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_flag_q <= RST_POR_FLAG;
      bor_flag_q <= RST_BOR_FLAG;
      to_q       <= RST_TO_FLAG;
      pd_q       <= RST_PD_FLAG;
      rsp_q      <= '0;
    end else begin
      por_flag_q <= por_flag_d;
      bor_flag_q <= bor_flag_d;
      to_q       <= to_d;
      pd_q       <= pd_d;
      rsp_q      <= rsp_d;
    end
  end

  always_comb begin
    apb_pready_o  = rsp_q.pready;
    apb_pslverr_o = rsp_q.pslverr;
    apb_prdata_o  = rsp_q.prdata;
    core_reset_o  = core_reset_q;
    sleeping_o    = sleep_q;
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_enter_power_up_delay_timer;
    (state_q != ST_POWER_UP_DELAY_TIMER) ##1 (state_q == ST_POWER_UP_DELAY_TIMER);
  endsequence

  sequence s_quiet_pin;
    pin_fall && !sleep_q && !por_pulse_i && !bor_evt && !wdt_timeout_i
      && !wr_done && !sleep_cmd_i;
  endsequence

  a_power_up_delay_timer_holds: assert property (
    state_q == ST_POWER_UP_DELAY_TIMER |-> core_reset_o)
    else $error("core left reset during power-up delay");

  a_power_up_delay_timer_cause: assert property (
    s_enter_power_up_delay_timer |-> $past(start_power_up_delay_timer_q))
    else $error("power-up delay started by wrong cause");

  a_power_up_delay_timer_fuse: assert property (
    s_enter_power_up_delay_timer |-> !$past(fuse_i.delay_timer_disable_fuse))
    else $error("power-up delay ran with fuse set");

  a_ost_crystal: assert property (
    state_q == ST_OST |-> is_crystal(fuse_i.osc_mode))
    else $error("start-up count in non-crystal mode");

  a_bor_sleep: assert property (
    fuse_i.brownout_mode_fuse == BOR_NO_SLEEP && sleep_q |-> !bor_en)
    else $error("brown-out active in sleep with mode 10");

  a_bor_filter: assert property (
    bor_evt |-> $past(vdd_low_i, 1) && bor_cnt_q == BOR_LAST)
    else $error("brown-out raised before filter time");

  a_bor_restart: assert property (
    state_q == ST_POWER_UP_DELAY_TIMER && bor_evt |=> state_q == ST_HOLD ##0 start_power_up_delay_timer_q)
    else $error("brown-out did not restart delay");

  a_por_flags: assert property (
    por_pulse_i |=> !por_flag_q && to_q && pd_q)
    else $error("power-on flags wrong");

  a_bor_flag: assert property (
    bor_evt && !por_pulse_i |=> !bor_flag_q && to_q && pd_q)
    else $error("brown-out flags wrong");

  a_pin_run: assert property (
    s_quiet_pin |=> $stable(por_flag_q) && $stable(bor_flag_q)
      && $stable(to_q) && $stable(pd_q))
    else $error("pin reset in run changed flags");

  a_ec_direct: assert property (
    state_q == ST_HOLD && vdd_ok && !por_pulse_i && !bor_evt
      && !wdt_reset && fuse_i.delay_timer_disable_fuse
      && fuse_i.osc_mode == OSC_EC |=> state_q == ST_RUN)
    else $error("external clock mode did not leave reset at once");

  a_pin_late: assert property (
    state_q == ST_RUN && state_d == ST_RUN && ext_reset_pin_n_i
      |=> !core_reset_o)
    else $error("late pin release did not run at once");

endmodule : rts_sequencer

/* File: tb/rts_far_model.sv */
// Purpose: far side of the sequencer: oscillator ticks, power-on pulse
// Assumes: detector outputs already synchronous to the reference clock
// Notes:   oscillator runs free, one tick every third reference cycle
`timescale 1ns/1ns
module rts_far_model (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic pwr_cycle_i,
  output logic      osc_tick_o,
  output logic      por_pulse_o
);
  logic [1:0] div_q;
  logic [2:0] por_cnt_q;

  assign osc_tick_o  = (div_q == 2'h2);
  // Pulse outlasts one cycle, as the analog detector would
  assign por_pulse_o = (por_cnt_q != 3'h0);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q     <= 2'h0;
      por_cnt_q <= 3'h0;
    end else begin
      div_q     <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      por_cnt_q <= pwr_cycle_i ? 3'h4 : por_cnt_q - 3'(por_cnt_q != 3'h0);
    end
  end
endmodule : rts_far_model

/* File: tb/tb_rts_sequencer.sv */
// Purpose: self-checking bench of the reset time-out sequencer
// Assumes: shortened counts, osc tick every third cycle
// Notes:   time-outs judged within a window; flags by a bench model
`timescale 1ns/1ns
module tb_rts_sequencer;
  import rts_pkg::*;
  localparam int PT = 8;
  localparam int RD = 2;
  localparam int OP = 4;
  localparam logic [11:0] CA = {IDX_RESET_CAUSE, 2'h0};
  localparam logic [11:0] SA = {IDX_STATUS_WORD, 2'h0};
  logic ref_clk = 1'b0, resetn = 1'b0, vdd_low = 1'b0, wdt = 1'b0;
  logic sleep_cmd = 1'b0, irq_wake = 1'b0, pin_n = 1'b1, pwr_cycle = 1'b0;
  logic osc_tick, por, pready, pslverr, core_rst, sleeping, perr;
  logic [31:0]  prdata, rd;
  rts_fuse_t    fuse = '{1'b1, BOR_ALWAYS, OSC_EC};
  rts_apb_req_t apb = '0;
  logic [2:0]   oscs [6] = '{3'h0, 3'h1, OSC_HS, OSC_EC, 3'h4, 3'h6};
  int fail_count = 0, compares = 0, n;
  bit por_f = 0, bor_f = 0, to_f = 1, pd_f = 1;

  rts_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(PT), .RC_DIV(RD), .OST_PERIODS(OP),
    .BOR_FILT_CYC(3)) i_rts_sequencer (.ref_clk_i(ref_clk),
    .resetn_i(resetn), .fuse_i(fuse), .por_pulse_i(por),
    .vdd_low_i(vdd_low), .osc_tick_i(osc_tick), .wdt_timeout_i(wdt),
    .sleep_cmd_i(sleep_cmd), .irq_wake_i(irq_wake),
    .ext_reset_pin_n_i(pin_n), .apb_i(apb), .apb_pready_o(pready),
    .apb_pslverr_o(pslverr), .apb_prdata_o(prdata),
    .core_reset_o(core_rst), .sleeping_o(sleeping));
  rts_far_model i_rts_far_model (.clk_i(ref_clk), .rstn_i(resetn),
    .pwr_cycle_i(pwr_cycle), .osc_tick_o(osc_tick), .por_pulse_o(por));

  always #50 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [31:0] got, exp, input string s);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %0h exp %0h", $time, s, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, exp, input string s);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask : check_flag

  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : tick

  // Request held until pready is seen at an edge
  task automatic apb_xfer(input logic wr, input logic [11:0] a,
                          input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    apb <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge ref_clk);
    apb.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    perr = pslverr;
    apb <= '0;
    if (k == 20) begin
      fail_count++;
      complete_run();
    end
  endtask : apb_xfer

  task automatic wr_cause(input logic [31:0] v);
    apb_xfer(1'b1, CA, v);
    por_f = v[1];
    bor_f = v[0];
  endtask : wr_cause

  // Brown-out flag is a don't-care after power-on, hence the mask
  task automatic chk_regs(input logic [31:0] m);
    apb_xfer(1'b0, CA, 32'h0);
    check_word(rd & m, {30'h0, por_f, bor_f} & m, "cause");
    apb_xfer(1'b0, SA, 32'h0);
    check_word(rd, {27'h0, to_f, pd_f, 3'h0}, "status");
  endtask : chk_regs

  // One-cycle strobes, bits {pwr_cycle, wdt, sleep_cmd, irq_wake}
  task automatic pulse(input logic [3:0] m);
    {pwr_cycle, wdt, sleep_cmd, irq_wake} <= m;
    @(posedge ref_clk);
    {pwr_cycle, wdt, sleep_cmd, irq_wake} <= 4'h0;
    tick(2);
  endtask : pulse

  task automatic time_out(input bit dly, xtal, input string s);
    for (n = 0; n < 50 && por === 1'b1; n++) @(posedge ref_clk);
    for (n = 0; n < 200 && core_rst !== 1'b0; n++) @(posedge ref_clk);
    check_flag(n >= (dly ? PT*RD-RD : 0) + (xtal ? (OP-1)*3 : 0) &&
      n <= (dly ? PT*RD+RD : 0) + (xtal ? OP*3 : 0) + 4, 1'b1, s);
    if (n == 200) complete_run();
  endtask : time_out

  initial begin
    void'($urandom(63));
    tick(4);
    resetn <= 1'b1;
    tick(4);
    chk_regs(32'h3);
    repeat (4) begin
      wr_cause($urandom);
      chk_regs(32'h3);
    end
    apb_xfer(1'b0, 12'h100, 32'h0);
    check_flag(perr, 1'b1, "unmapped");
    check_word(rd, 32'h0, "unmapped data");
    apb_xfer(1'b1, SA, 32'h0);
    chk_regs(32'h3);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      fuse <= '{i[0], BOR_ALWAYS, oscs[i/2]};
      wr_cause(32'h3);
      pulse(4'h8);
      {por_f, to_f, pd_f} = 3'b011;
      time_out(!i[0], oscs[i/2] < OSC_EC, "power-up");
      chk_regs(32'h2);
    end
    $display("test power-up done");
    fuse <= '{1'b0, BOR_ALWAYS, OSC_EC};
    wr_cause(32'h3);
    vdd_low <= 1'b1;
    tick(2);
    vdd_low <= 1'b0;
    tick(4);
    check_flag(core_rst, 1'b0, "short dip");
    vdd_low <= 1'b1;
    tick(10);
    check_flag(core_rst, 1'b1, "low supply");
    {bor_f, to_f, pd_f} = 3'b011;
    vdd_low <= 1'b0;
    tick(8);
    vdd_low <= 1'b1;
    tick(6);
    check_flag(core_rst, 1'b1, "dip in delay");
    vdd_low <= 1'b0;
    time_out(1'b1, 1'b0, "restart");
    chk_regs(32'h3);
    $display("test brown-out done");
    pulse(4'h4);
    to_f = 0;
    tick(3);
    check_flag(core_rst, 1'b0, "wdt no delay");
    chk_regs(32'h3);
    pulse(4'h2);
    {to_f, pd_f} = 2'b10;
    check_flag(sleeping, 1'b1, "sleep");
    chk_regs(32'h3);
    pulse(4'h4);
    {to_f, pd_f} = 2'b00;
    tick(3);
    check_flag(sleeping, 1'b0, "wdt wake");
    chk_regs(32'h3);
    $display("test watchdog done");
    fuse <= '{1'b0, BOR_NO_SLEEP, OSC_EC};
    pulse(4'h2);
    {to_f, pd_f} = 2'b10;
    vdd_low <= 1'b1;
    tick(8);
    check_flag(core_rst, 1'b0, "no bor asleep");
    vdd_low <= 1'b0;
    pulse(4'h1);
    check_flag(sleeping, 1'b0, "irq wake");
    chk_regs(32'h3);
    vdd_low <= 1'b1;
    tick(8);
    check_flag(core_rst, 1'b1, "bor awake");
    {bor_f, to_f, pd_f} = 3'b011;
    vdd_low <= 1'b0;
    time_out(1'b1, 1'b0, "bor awake");
    fuse <= '{1'b0, 2'h1, OSC_EC};
    vdd_low <= 1'b1;
    tick(8);
    check_flag(core_rst, 1'b0, "bor off");
    vdd_low <= 1'b0;
    $display("test brown-out modes done");
    pulse(4'h2);
    pin_n <= 1'b0;
    tick(3);
    check_flag(core_rst, 1'b1, "pin asleep");
    pin_n <= 1'b1;
    {to_f, pd_f} = 2'b10;
    tick(4);
    check_flag(sleeping | core_rst, 1'b0, "pin wake");
    chk_regs(32'h3);
    pin_n <= 1'b0;
    tick(3);
    check_flag(core_rst, 1'b1, "pin in run");
    pin_n <= 1'b1;
    tick(2);
    check_flag(core_rst, 1'b0, "pin release");
    chk_regs(32'h3);
    pin_n <= 1'b0;
    pulse(4'h8);
    {por_f, to_f, pd_f} = 3'b011;
    tick(30);
    check_flag(core_rst, 1'b1, "pin held");
    pin_n <= 1'b1;
    tick(2);
    check_flag(core_rst, 1'b0, "late release");
    chk_regs(32'h2);
    $display("test reset pin done");
    complete_run();
  end
endmodule : tb_rts_sequencer
